/* rtl/flash_program_erase_control.sv */
// key-guarded flash program/erase sequencer with core stall and a debug program path that bypasses the key
`timescale 1ns/1ps
module flash_program_erase_control #(
  parameter int FLASH_BYTES = 8192,
  parameter int WRITE_CYCLES = fpk::WRITE_CYCLES,
  parameter int ERASE_CYCLES = fpk::ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire fpk::xmove_t xmove,
  output logic xram_wr,
  output logic [fpk::ADDR_W-1:0] xram_addr,
  output logic [7:0] xram_data,
  output logic core_stall,
  input wire logic dbg_wr,
  input wire logic [fpk::ADDR_W-1:0] dbg_addr,
  input wire logic [7:0] dbg_data,
  output logic dbg_busy,
  input wire logic [fpk::ADDR_W-1:0] fetch_addr,
  output logic [7:0] fetch_data
);
  if (WRITE_CYCLES < 1 || ERASE_CYCLES < fpk::PAGE_BYTES) begin : bad_timing
    $error("write needs a cycle and erase must cover a page sweep");
  end

  // control registers
  logic swe_ff;
  logic see_ff;
  logic fwt_ff;
  logic [7:0] rdata_ff;
  // sequencer state
  fpk::key_state_t key_ff;
  fpk::key_state_t nxt_key;
  fpk::op_state_t op_ff;
  fpk::op_state_t nxt_op;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [fpk::ADDR_W-1:0] op_addr_ff;
  logic [7:0] op_data_ff;
  logic busy_ff;
  logic xram_wr_ff;
  logic [fpk::ADDR_W-1:0] xram_addr_ff;
  logic [7:0] xram_data_ff;
  fpk::store_cmd_t store_cmd;

  // decode
  wire key_wr = reg_wr && (reg_addr == fpk::REG_KEY);
  wire ctl_wr = reg_wr && (reg_addr == fpk::REG_STORE_CTL);
  wire scale_wr = reg_wr && (reg_addr == fpk::REG_SCALE);
  wire key_is_first = (reg_wdata == fpk::KEY_FIRST_CODE);
  wire key_is_second = (reg_wdata == fpk::KEY_SECOND_CODE);
  // an 8-bit form cannot reach flash beyond the low window
  wire addr8_out = xmove.addr8 && (xmove.addr > fpk::ADDR8_LIMIT);
  wire to_flash = xmove.valid && swe_ff && !addr8_out;
  wire to_xram = xmove.valid && !swe_ff;
  wire is_armed = (key_ff == fpk::KEY_ARMED);
  wire op_idle = (op_ff == fpk::OP_IDLE);
  wire core_start = to_flash && is_armed && op_idle;
  wire violate = to_flash && !is_armed;
  // core request wins; a debug request is refused while anything runs
  wire dbg_start = dbg_wr && op_idle && !core_start;
  wire [31:0] op_len = (op_ff == fpk::OP_ERASE) ? 32'(ERASE_CYCLES) : 32'(WRITE_CYCLES);
  wire op_last = !op_idle && (cnt_ff == op_len - 32'd1);
  wire op_done = op_last;
  wire [fpk::ADDR_W-1:0] page_base = {op_addr_ff[fpk::ADDR_W-1:fpk::PAGE_W],
                                      {fpk::PAGE_W{1'b0}}};
  wire sweep = (op_ff == fpk::OP_ERASE) && (cnt_ff < 32'(fpk::PAGE_BYTES));

  // key logic: locked, first, armed, sticky disabled
  always_comb begin
    nxt_key = key_ff;
    case (key_ff)
      fpk::KEY_LOCKED: begin
        if (violate) begin
          nxt_key = fpk::KEY_DISABLED;
        end else if (key_wr) begin
          nxt_key = key_is_first ? fpk::KEY_FIRST : fpk::KEY_DISABLED;
        end
      end
      fpk::KEY_FIRST: begin
        // no timeout here: the first code may wait forever
        if (violate) begin
          nxt_key = fpk::KEY_DISABLED;
        end else if (key_wr) begin
          nxt_key = key_is_second ? fpk::KEY_ARMED : fpk::KEY_DISABLED;
        end
      end
      fpk::KEY_ARMED: begin
        if (key_wr) begin
          nxt_key = fpk::KEY_DISABLED;
        end else if (core_start) begin
          nxt_key = fpk::KEY_LOCKED;
        end
      end
      fpk::KEY_DISABLED: begin
        nxt_key = fpk::KEY_DISABLED;
      end
      default: begin
        nxt_key = fpk::KEY_DISABLED;
      end
    endcase
  end

  // operation timer
  always_comb begin
    nxt_op = op_ff;
    nxt_cnt = cnt_ff;
    case (op_ff)
      fpk::OP_IDLE: begin
        nxt_cnt = 32'd0;
        if (core_start) begin
          nxt_op = see_ff ? fpk::OP_ERASE : fpk::OP_WRITE;
        end else if (dbg_start) begin
          nxt_op = fpk::OP_WRITE;
        end
      end
      fpk::OP_WRITE, fpk::OP_ERASE: begin
        nxt_cnt = cnt_ff + 32'd1;
        if (op_done) begin
          nxt_op = fpk::OP_IDLE;
          nxt_cnt = 32'd0;
        end
      end
      default: begin
        nxt_op = fpk::OP_IDLE;
        nxt_cnt = 32'd0;
      end
    endcase
  end

  // program lands on the first cycle, erase sweeps the page one byte a cycle
  assign store_cmd.we = ((op_ff == fpk::OP_WRITE) && (cnt_ff == 32'd0)) || sweep;
  assign store_cmd.erase = (op_ff == fpk::OP_ERASE);
  assign store_cmd.addr = sweep ? (page_base | {{(fpk::ADDR_W-fpk::PAGE_W){1'b0}},
                                                cnt_ff[fpk::PAGE_W-1:0]})
                                : op_addr_ff;
  assign store_cmd.data = op_data_ff;

  wire [7:0] status = {4'h0, key_ff == fpk::KEY_FIRST, key_ff == fpk::KEY_DISABLED,
                       is_armed, busy_ff};
  wire [7:0] nxt_rdata =
    !reg_rd ? 8'h00 :
    (reg_addr == fpk::REG_STORE_CTL) ? {6'h00, see_ff, swe_ff} :
    (reg_addr == fpk::REG_KEY) ? {6'h00, key_ff} :
    (reg_addr == fpk::REG_SCALE) ? {3'h0, fwt_ff, 4'h0} : status;

  always_ff @(posedge clk) begin
    if (rst) begin
      key_ff <= fpk::KEY_LOCKED;
      op_ff <= fpk::OP_IDLE;
      cnt_ff <= 32'd0;
      busy_ff <= 1'b0;
    end else begin
      key_ff <= nxt_key;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_op != fpk::OP_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_addr_ff <= '0;
      op_data_ff <= 8'h00;
    end else if (core_start) begin
      op_addr_ff <= xmove.addr;
      op_data_ff <= xmove.data;
    end else if (dbg_start) begin
      op_addr_ff <= dbg_addr;
      op_data_ff <= dbg_data;
    end
  end

  // the enables hold until software writes them again
  always_ff @(posedge clk) begin
    if (rst) begin
      swe_ff <= fpk::STORE_CTL_RST[fpk::SWE_BIT];
      see_ff <= fpk::STORE_CTL_RST[fpk::SEE_BIT];
      fwt_ff <= fpk::SCALE_RST[fpk::FWT_BIT];
    end else begin
      if (ctl_wr) begin
        swe_ff <= reg_wdata[fpk::SWE_BIT];
        see_ff <= reg_wdata[fpk::SEE_BIT];
      end
      if (scale_wr) begin
        fwt_ff <= reg_wdata[fpk::FWT_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      xram_wr_ff <= 1'b0;
      xram_addr_ff <= '0;
      xram_data_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
      xram_wr_ff <= to_xram;
      if (to_xram) begin
        xram_addr_ff <= xmove.addr;
        xram_data_ff <= xmove.data;
      end
    end
  end

  flash_store #(
    .DEPTH(FLASH_BYTES)
  ) u_store (
    .clk(clk),
    .cmd(store_cmd),
    .rd_addr(fetch_addr),
    .rd_data(fetch_data)
  );

  assign reg_rdata = rdata_ff;
  assign xram_wr = xram_wr_ff;
  assign xram_addr = xram_addr_ff;
  assign xram_data = xram_data_ff;
  assign core_stall = busy_ff;
  assign dbg_busy = busy_ff;

  // checking helpers
  logic [31:0] busy_len_ff;
  logic last_erase_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_len_ff <= 32'd0;
      last_erase_ff <= 1'b0;
    end else begin
      busy_len_ff <= busy_ff ? busy_len_ff + 32'd1 : 32'd0;
      if (op_ff != fpk::OP_IDLE) begin
        last_erase_ff <= (op_ff == fpk::OP_ERASE);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence first_key_s;
    key_ff == fpk::KEY_LOCKED && key_wr && key_is_first && !violate;
  endsequence
  sequence second_key_s;
    key_wr && key_is_second && !violate;
  endsequence
  sequence core_program_s;
    core_start && !see_ff;
  endsequence
  sequence core_erase_s;
    core_start && see_ff;
  endsequence

  key_pair_arms_a: assert property (
    first_key_s ##1 (!key_wr && !violate) ##1 second_key_s |=> is_armed)
    else $error("ordered key pair did not arm");
  bad_first_key_a: assert property (
    key_ff == fpk::KEY_LOCKED && key_wr && !key_is_first |=> key_ff == fpk::KEY_DISABLED)
    else $error("wrong first key did not disable");
  disabled_sticks_a: assert property (
    key_ff == fpk::KEY_DISABLED && op_idle && !dbg_start |=>
      key_ff == fpk::KEY_DISABLED && op_idle)
    else $error("disabled state was left before reset");
  unarmed_attempt_a: assert property (
    violate |=> key_ff == fpk::KEY_DISABLED ##1 op_ff == fpk::OP_IDLE)
    else $error("unarmed attempt did not disable");
  relock_after_op_a: assert property (
    core_start |=> !is_armed [*3])
    else $error("key stayed armed after an operation");
  op_timed_a: assert property (
    $fell(busy_ff) |->
      busy_len_ff == (last_erase_ff ? 32'(ERASE_CYCLES) : 32'(WRITE_CYCLES)))
    else $error("operation length differs from its timing");
  stall_cover_a: assert property (
    (core_start || dbg_start) |=> core_stall throughout (op_ff != fpk::OP_IDLE))
    else $error("core not stalled during operation");
  erase_in_page_a: assert property (
    sweep |-> store_cmd.we && store_cmd.erase &&
      store_cmd.addr[fpk::ADDR_W-1:fpk::PAGE_W] == op_addr_ff[fpk::ADDR_W-1:fpk::PAGE_W])
    else $error("erase sweep left its page");
  addr8_guard_a: assert property (
    xmove.valid && swe_ff && addr8_out && op_idle |=> !busy_ff && !xram_wr)
    else $error("8-bit address above limit reached storage");
  steer_xram_a: assert property (
    xmove.valid && !swe_ff |=> xram_wr && xram_addr == $past(xmove.addr) && !busy_ff)
    else $error("write not steered to data memory");

  // key logic, one step at a time
  second_key_arms_a: assert property (
    key_ff == fpk::KEY_FIRST && second_key_s |=> is_armed)
    else $error("second key after any wait did not arm");
  bad_second_key_a: assert property (
    key_ff == fpk::KEY_FIRST && key_wr && !key_is_second |=> key_ff == fpk::KEY_DISABLED)
    else $error("wrong second key did not disable");
  armed_key_wr_a: assert property (
    is_armed && key_wr |=> key_ff == fpk::KEY_DISABLED)
    else $error("key write while armed did not disable");
  first_key_waits_a: assert property (
    key_ff == fpk::KEY_FIRST && !key_wr && !violate |=> key_ff == fpk::KEY_FIRST)
    else $error("first key state left without a key write");
  short_addr_kept_a: assert property (
    xmove.valid && swe_ff && addr8_out && !key_wr |=> key_ff == $past(key_ff))
    else $error("ignored short-address write changed the key state");

  // operation start and length
  program_starts_a: assert property (
    core_program_s |=> op_ff == fpk::OP_WRITE && store_cmd.we && !store_cmd.erase &&
      store_cmd.addr == $past(xmove.addr) && store_cmd.data == $past(xmove.data))
    else $error("program did not land on the addressed byte");
  program_once_a: assert property (
    op_ff == fpk::OP_WRITE && cnt_ff != 32'd0 |-> !store_cmd.we)
    else $error("program wrote more than one byte");
  erase_starts_a: assert property (
    core_erase_s |=> op_ff == fpk::OP_ERASE && store_cmd.addr[fpk::PAGE_W-1:0] == '0 &&
      (store_cmd.addr >> fpk::PAGE_W) == ($past(xmove.addr) >> fpk::PAGE_W))
    else $error("erase did not start at the page base");
  sweep_covers_page_a: assert property (
    $fell(sweep) |-> $past(cnt_ff) == 32'(fpk::PAGE_BYTES - 1))
    else $error("erase sweep stopped short of the page end");
  stall_while_op_a: assert property (
    op_ff != fpk::OP_IDLE |-> core_stall && dbg_busy)
    else $error("core ran while an operation was in progress");

  // debug path and register port
  debug_program_a: assert property (
    dbg_start |=> op_ff == fpk::OP_WRITE && store_cmd.we && !store_cmd.erase &&
      store_cmd.addr == $past(dbg_addr) && store_cmd.data == $past(dbg_data))
    else $error("debug program did not land on its byte");
  debug_refused_a: assert property (
    dbg_wr && !op_idle |=> !(op_ff == fpk::OP_WRITE && cnt_ff == 32'd0))
    else $error("debug request started during an operation");
  flash_path_quiet_a: assert property (
    xmove.valid && swe_ff |=> !xram_wr)
    else $error("flash-bound write leaked to data memory");
  enable_holds_a: assert property (
    !ctl_wr |=> $stable(swe_ff))
    else $error("store write enable changed without software");
  read_stands_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stood longer than one cycle");
endmodule

/* rtl/fpk.sv */
// constants, states and carriers for the flash program/erase sequencer
package fpk;
  localparam int ADDR_W = 16;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_W = 9;
  localparam logic [7:0] KEY_FIRST_CODE = 8'hA5;
  localparam logic [7:0] KEY_SECOND_CODE = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ADDR8_LIMIT = 16'h00FF;
  // register offsets on the plain register port
  localparam logic [1:0] REG_STORE_CTL = 2'h0;
  localparam logic [1:0] REG_KEY = 2'h1;
  localparam logic [1:0] REG_SCALE = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  // field positions
  localparam int SWE_BIT = 0;
  localparam int SEE_BIT = 1;
  localparam int FWT_BIT = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_DISABLED_BIT = 2;
  localparam int ST_FIRST_BIT = 3;
  // reset values
  localparam logic [7:0] STORE_CTL_RST = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 20000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_FIRST, KEY_ARMED, KEY_DISABLED} key_state_t;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} op_state_t;

  typedef struct packed {
    logic valid;
    logic addr8;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } xmove_t;

  typedef struct packed {
    logic we;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } store_cmd_t;
endpackage

/* rtl/flash_store.sv */
// flash cell array: program clears bits, erase byte sets all ones
`timescale 1ns/1ps
module flash_store #(
  parameter int DEPTH = 8192
) (
  input wire logic clk,
  input wire fpk::store_cmd_t cmd,
  input wire logic [fpk::ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  // a blank part starts erased
  logic [7:0] mem [DEPTH] = '{default: fpk::ERASED_BYTE};
  logic [AW-1:0] wa;
  logic [AW-1:0] ra;
  logic [7:0] old_ff;
  logic [AW-1:0] last_addr_ff;
  logic last_prog_ff;

  // the address is cut to its low bits, so the depth must be a power of two
  if (DEPTH < fpk::PAGE_BYTES || (DEPTH % fpk::PAGE_BYTES) != 0 ||
      (DEPTH & (DEPTH - 1)) != 0 || DEPTH > (1 << fpk::ADDR_W)) begin : bad_depth
    $error("flash depth must be a power-of-two number of pages");
  end

  assign wa = cmd.addr[AW-1:0];
  assign ra = rd_addr[AW-1:0];

  always_ff @(posedge clk) begin
    if (cmd.we) begin
      mem[wa] <= cmd.erase ? fpk::ERASED_BYTE : (mem[wa] & cmd.data);
    end
    rd_data <= mem[ra];
  end

  always_ff @(posedge clk) begin
    old_ff <= mem[wa];
    last_addr_ff <= wa;
    last_prog_ff <= cmd.we && !cmd.erase;
  end

  no_bit_rise_a: assert property (@(posedge clk)
    last_prog_ff |-> ((mem[last_addr_ff] & ~old_ff) == 8'h00))
    else $error("program write set a bit to one");
endmodule

/* tb/core_model.sv */
// core-side model: issues external-move writes and honours the stall
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic core_stall,
  output fpk::xmove_t xmove
);
  initial xmove = '0;
  // released lines flip so a stale address or data byte can never pass for a fresh one
  // the model takes no interrupts, so nothing splits a key pair from its write
  task automatic move(input logic a8, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    while (core_stall === 1'b1) @(posedge clk);
    xmove <= '{valid: 1'b1, addr8: a8, addr: a, data: d};
    @(posedge clk);
    xmove <= '{valid: 1'b0, addr8: ~a8, addr: ~a, data: ~d};
  endtask
endmodule

/* tb/flash_program_erase_control_test.sv */
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module flash_program_erase_control_test;
  localparam int WC = 4;
  localparam int EC = 600;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  fpk::xmove_t xmove;
  logic xram_wr;
  logic [15:0] xram_addr;
  logic [7:0] xram_data;
  logic [7:0] fetch_data;
  logic core_stall;
  logic dbg_busy;
  logic dbg_wr = 1'b0;
  logic [15:0] dbg_addr = 16'h0000;
  logic [7:0] dbg_data = 8'h00;
  logic [15:0] fetch_addr = 16'h0000;
  int errors = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  flash_program_erase_control #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xmove(xmove), .xram_wr(xram_wr),
    .xram_addr(xram_addr), .xram_data(xram_data), .core_stall(core_stall),
    .dbg_wr(dbg_wr), .dbg_addr(dbg_addr), .dbg_data(dbg_data), .dbg_busy(dbg_busy),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data)
  );

  core_model core (.clk(clk), .core_stall(core_stall), .xmove(xmove));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(fpk::REG_SCALE, 8'h10);
  endtask

  // the leading edge keeps two back-to-back calls from driving a strobe twice at once
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  task automatic peek(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    fetch_addr <= a;
    @(posedge clk);
    #1;
    `CHK(fetch_data, exp)
  endtask

  task automatic keys;
    wr(fpk::REG_KEY, fpk::KEY_FIRST_CODE);
    wr(fpk::REG_KEY, fpk::KEY_SECOND_CODE);
  endtask

  // counts stall cycles after the launching edge; zero means nothing started
  task automatic span(input int exp);
    int n;
    n = 0;
    #1;
    while (core_stall === 1'b1 && n < 5000) begin
      n++;
      @(posedge clk);
      #1;
    end
    `CHK(n, exp)
  endtask

  task automatic t_regs;
    rd(fpk::REG_STORE_CTL, fpk::STORE_CTL_RST);
    rd(fpk::REG_KEY, 8'h00);
    rd(fpk::REG_STATUS, 8'h00);
    rd(fpk::REG_SCALE, fpk::SCALE_RST);
    wr(fpk::REG_SCALE, 8'h10);
    rd(fpk::REG_SCALE, 8'h10);
    wr(fpk::REG_STORE_CTL, 8'h03);
    rd(fpk::REG_STORE_CTL, 8'h03);
    wr(fpk::REG_STORE_CTL, 8'h00);
    core.move(1'b0, 16'h1234, 8'h5A);
    #1;
    `CHK(xram_wr, 1'b1)
    `CHK(xram_addr, 16'h1234)
    `CHK(xram_data, 8'h5A)
    span(0);
    $display("test regs done");
  endtask

  task automatic t_program;
    wr(fpk::REG_STORE_CTL, 8'h01);
    wr(fpk::REG_KEY, fpk::KEY_FIRST_CODE);
    repeat (40) @(posedge clk);
    rd(fpk::REG_KEY, 8'h01);
    wr(fpk::REG_KEY, fpk::KEY_SECOND_CODE);
    rd(fpk::REG_KEY, 8'h02);
    core.move(1'b0, 16'h0210, 8'h3C);
    span(WC);
    rd(fpk::REG_KEY, 8'h00);
    peek(16'h0210, 8'h3C);
    keys();
    core.move(1'b0, 16'h0210, 8'hF0);
    span(WC);
    peek(16'h0210, 8'h30);
    core.move(1'b0, 16'h0211, 8'h00);
    span(0);
    rd(fpk::REG_KEY, 8'h03);
    peek(16'h0211, fpk::ERASED_BYTE);
    do_reset();
    $display("test program done");
  endtask

  task automatic t_erase;
    wr(fpk::REG_STORE_CTL, 8'h01);
    keys();
    core.move(1'b0, 16'h0400, 8'h12);
    span(WC);
    wr(fpk::REG_STORE_CTL, 8'h03);
    keys();
    core.move(1'b0, 16'h0345, 8'h00);
    span(EC);
    peek(16'h0210, fpk::ERASED_BYTE);
    peek(16'h0200, fpk::ERASED_BYTE);
    peek(16'h03FF, fpk::ERASED_BYTE);
    peek(16'h0400, 8'h12);
    wr(fpk::REG_STORE_CTL, 8'h00);
    $display("test erase done");
  endtask

  task automatic t_lockout;
    wr(fpk::REG_KEY, fpk::KEY_FIRST_CODE);
    wr(fpk::REG_KEY, 8'h00);
    rd(fpk::REG_KEY, 8'h03);
    keys();
    rd(fpk::REG_STATUS, 8'h04);
    wr(fpk::REG_STORE_CTL, 8'h01);
    core.move(1'b0, 16'h0500, 8'h00);
    span(0);
    peek(16'h0500, fpk::ERASED_BYTE);
    do_reset();
    wr(fpk::REG_KEY, fpk::KEY_SECOND_CODE);
    rd(fpk::REG_KEY, 8'h03);
    do_reset();
    keys();
    wr(fpk::REG_KEY, fpk::KEY_FIRST_CODE);
    rd(fpk::REG_KEY, 8'h03);
    do_reset();
    $display("test lockout done");
  endtask

  task automatic t_short_addr;
    wr(fpk::REG_STORE_CTL, 8'h01);
    keys();
    core.move(1'b1, 16'h0180, 8'h00);
    span(0);
    peek(16'h0180, fpk::ERASED_BYTE);
    rd(fpk::REG_KEY, 8'h02);
    core.move(1'b1, 16'h0080, 8'h55);
    span(WC);
    peek(16'h0080, 8'h55);
    wr(fpk::REG_STORE_CTL, 8'h00);
    $display("test short address done");
  endtask

  task automatic t_debug;
    @(posedge clk);
    dbg_wr <= 1'b1;
    dbg_addr <= 16'h0600;
    dbg_data <= 8'h66;
    @(posedge clk);
    dbg_wr <= 1'b0;
    dbg_addr <= 16'hF9FF;
    dbg_data <= 8'h99;
    #1;
    `CHK(dbg_busy, 1'b1)
    span(WC);
    peek(16'h0600, 8'h66);
    $display("test debug done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_program();
    t_erase();
    t_lockout();
    t_short_addr();
    t_debug();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
